// file: pkg/pfd_map.svh
`ifndef PFD_MAP_SVH
`define PFD_MAP_SVH

// local bus and instruction word layout
`define PFD_BUS_W 32
`define PFD_OP_HI 31
`define PFD_OP_LO 16
`define PFD_OP_W 16
`define PFD_GRP_HI 15
`define PFD_GRP_LO 12
`define PFD_EXT_BIT 11

// fetch address handling
`define PFD_RESET_PC 32'h0000_0000
`define PFD_ADDR_STEP 32'h0000_0004
`define PFD_WORD_MASK 32'hffff_fffc
`define PFD_ALIGN_HI 1
`define PFD_ALIGN_ZERO 2'h0

// opcode groups that the early decode table tells apart
`define PFD_GRP_LOAD 4'h2
`define PFD_GRP_STORE 4'h3
`define PFD_GRP_BRANCH 4'h6

// instruction length in 16-bit words
`define PFD_LEN_ONE 2'h1
`define PFD_LEN_TWO 2'h2
`define PFD_LEN_THREE 2'h3

// operand pipe execution cycles
`define PFD_EXEC_BASE 2'h1
`define PFD_EXEC_MEMRD 2'h2

`endif

// file: pkg/pfd_pkg.sv
`include "pfd_map.svh"

package pfd_pkg;

    // control vector produced by the early decode stage
    typedef struct packed {
        logic [1:0] len;
        logic mem_read;
        logic mem_write;
        logic branch;
        logic [1:0] exec_cycles;
    } pfd_ctrl_t;

    // one machine instruction handed to the operand execution pipe
    typedef struct packed {
        logic [`PFD_BUS_W-1:0] addr;
        logic [`PFD_BUS_W-1:0] instr;
        pfd_ctrl_t ctrl;
    } pfd_item_t;

    // opcode indexes a fixed table of control vectors
    function automatic pfd_ctrl_t pfd_decode(input logic [`PFD_OP_W-1:0] op);
        pfd_ctrl_t c;
        c = '0;
        c.len = `PFD_LEN_ONE;
        c.exec_cycles = `PFD_EXEC_BASE;
        case (op[`PFD_GRP_HI:`PFD_GRP_LO])
            `PFD_GRP_LOAD: begin
                c.mem_read = 1'h1;
                c.len = `PFD_LEN_TWO;
            end
            `PFD_GRP_STORE: begin
                c.mem_write = 1'h1;
                c.len = `PFD_LEN_TWO;
            end
            `PFD_GRP_BRANCH: begin
                c.branch = 1'h1;
                c.len = op[`PFD_EXT_BIT] ? `PFD_LEN_THREE : `PFD_LEN_TWO;
            end
            default: begin
                c.len = `PFD_LEN_ONE;
            end
        endcase
        // memory reads pay one extra cycle for the pipelined bus
        if (c.mem_read) begin
            c.exec_cycles = `PFD_EXEC_MEMRD;
        end
        return c;
    endfunction : pfd_decode

endpackage : pfd_pkg

// file: src/pfd_skid_buf.sv
`timescale 1ns/1ps

// two-entry buffer: an output register plus one skid slot
module pfd_skid_buf (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_flush,
    input wire logic i_valid,
    input wire pfd_pkg::pfd_item_t i_data,
    output logic o_ready,
    output logic o_valid,
    output pfd_pkg::pfd_item_t o_data,
    input wire logic i_ready
);
    import pfd_pkg::*;

    logic skid_v;
    pfd_item_t skid_d;
    logic out_free;

    // ready comes from a flop so the upstream path stays short
    assign o_ready = ~skid_v;
    assign out_free = ~o_valid | i_ready;

    // occupancy flags
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_valid <= 1'h0;
            skid_v <= 1'h0;
        end else if (i_flush) begin
            o_valid <= 1'h0;
            skid_v <= 1'h0;
        end else if (out_free) begin
            o_valid <= skid_v | i_valid;
            skid_v <= 1'h0;
        end else if (i_valid && !skid_v) begin
            skid_v <= 1'h1; // receiver stalled, park the word
        end
    end

    // data slots
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_data <= '0;
            skid_d <= '0;
        end else if (out_free) begin
            if (skid_v) begin
                o_data <= skid_d;
            end else if (i_valid) begin
                o_data <= i_data;
            end
        end else if (i_valid && !skid_v) begin
            skid_d <= i_data;
        end
    end

endmodule : pfd_skid_buf

// file: src/pfd_fetch.sv
`timescale 1ns/1ps
`include "pfd_map.svh"

module pfd_fetch (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_redirect,
    input wire logic [`PFD_BUS_W-1:0] i_redirect_addr,
    output logic o_bus_req,
    output logic [`PFD_BUS_W-1:0] o_bus_addr,
    input wire logic [`PFD_BUS_W-1:0] i_bus_rdata,
    output logic o_inst_valid,
    output pfd_pkg::pfd_item_t o_inst,
    input wire logic i_inst_ready
);
    import pfd_pkg::*;

    // bus_array_cycle and bus_return_cycle trackers
    logic a1_v;
    logic [`PFD_BUS_W-1:0] a1_addr;
    logic a2_v;
    logic [`PFD_BUS_W-1:0] a2_addr;
    // early_decode_stage holding register
    logic ed_v;
    logic [`PFD_BUS_W-1:0] ed_addr;
    logic [`PFD_BUS_W-1:0] ed_instr;
    // control between stages
    logic buf_in_ready;
    logic ed_hold;
    logic replay;
    logic kill;
    logic [`PFD_BUS_W-1:0] next_fetch_addr;
    pfd_item_t ed_item;

    // the bus cannot be stalled, so a word returning into a blocked
    // decode stage is dropped and refetched instead of being stored
    assign ed_hold = ed_v & ~buf_in_ready;
    assign replay = a2_v & ed_hold;
    assign kill = i_redirect | replay;

    // fetch_address_stage: redirect beats replay beats sequential
    always_comb begin
        next_fetch_addr = o_bus_addr;
        if (i_redirect) begin
            next_fetch_addr = i_redirect_addr & `PFD_WORD_MASK;
        end else if (replay) begin
            next_fetch_addr = a2_addr;
        end else if (o_bus_req) begin
            next_fetch_addr = o_bus_addr + `PFD_ADDR_STEP;
        end
    end

    // request drive: memory registers o_bus_addr at every edge with o_bus_req
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_bus_req <= 1'h0;
            o_bus_addr <= `PFD_RESET_PC;
        end else begin
            o_bus_req <= 1'h1;
            o_bus_addr <= next_fetch_addr;
        end
    end

    // fetch_access_stage_one follows the memory's array cycle
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            a1_v <= 1'h0;
            a1_addr <= `PFD_RESET_PC;
        end else begin
            a1_v <= o_bus_req & ~kill;
            a1_addr <= o_bus_addr;
        end
    end

    // fetch_access_stage_two follows the return cycle; data arrives here
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            a2_v <= 1'h0;
            a2_addr <= `PFD_RESET_PC;
        end else begin
            a2_v <= a1_v & ~kill;
            a2_addr <= a1_addr;
        end
    end

    // early_decode_stage valid: cleared by redirect, held while queue is full
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ed_v <= 1'h0;
        end else if (i_redirect) begin
            ed_v <= 1'h0;
        end else if (!ed_hold) begin
            ed_v <= a2_v;
        end
    end

    // capture the returned word at the end of the return cycle
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ed_addr <= `PFD_RESET_PC;
            ed_instr <= '0;
        end else if (!ed_hold) begin
            ed_addr <= a2_addr;
            ed_instr <= i_bus_rdata;
        end
    end

    // decode runs during the early decode cycle, off the bus return path
    always_comb begin
        ed_item.addr = ed_addr;
        ed_item.instr = ed_instr;
        ed_item.ctrl = pfd_decode(ed_instr[`PFD_OP_HI:`PFD_OP_LO]);
    end

    // instruction_queue: its output register is the instruction register,
    // loaded with opcode, extension and control vector in one edge
    pfd_skid_buf u_queue (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_flush(i_redirect),
        .i_valid(ed_v),
        .i_data(ed_item),
        .o_ready(buf_in_ready),
        .o_valid(o_inst_valid),
        .o_data(o_inst),
        .i_ready(i_inst_ready)
    );

    // checks on the pipeline
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_issue;
        o_bus_req && !kill;
    endsequence

    sequence s_flushed;
        !a1_v && !a2_v && !ed_v && !o_inst_valid;
    endsequence

    sequence s_returned;
        a2_v && !ed_hold && !i_redirect;
    endsequence

    a_bus_word_align: assert property (
        o_bus_req |-> o_bus_addr[`PFD_ALIGN_HI:0] == `PFD_ALIGN_ZERO)
        else $error("fetch address not word aligned");

    a_access_two_cycles: assert property (
        s_issue ##1 !kill |=> a2_v && a2_addr == $past(o_bus_addr, 2))
        else $error("access did not reach the return cycle after two cycles");

    a_return_capture: assert property (
        s_returned |=> ed_v && ed_instr == $past(i_bus_rdata) && ed_addr == $past(a2_addr))
        else $error("returned word not captured into early decode");

    a_issue_every_cycle: assert property (
        o_bus_req |=> o_bus_req)
        else $error("request stream stopped");

    a_decode_before_pipe: assert property (
        $rose(o_inst_valid) |-> $past(ed_v) && o_inst.instr == $past(ed_instr))
        else $error("instruction did not come from early decode");

    a_ctrl_with_instr: assert property (
        o_inst_valid |-> o_inst.ctrl == pfd_decode(o_inst.instr[`PFD_OP_HI:`PFD_OP_LO]))
        else $error("control vector does not match instruction register");

    a_load_lookup: assert property (
        o_inst_valid && o_inst.instr[`PFD_OP_HI:`PFD_OP_HI-3] == `PFD_GRP_LOAD
        |-> o_inst.ctrl.mem_read && !o_inst.ctrl.mem_write && !o_inst.ctrl.branch)
        else $error("load opcode gave wrong table entry");

    a_stage_order: assert property (
        a1_v && a2_v |-> a1_addr == a2_addr + `PFD_ADDR_STEP)
        else $error("access stages out of sequence");

    a_exec_extra: assert property (
        o_inst_valid |-> o_inst.ctrl.exec_cycles ==
            (o_inst.ctrl.mem_read ? `PFD_EXEC_MEMRD : `PFD_EXEC_BASE))
        else $error("execution cycle count wrong");

    a_redirect_discard: assert property (
        i_redirect |=> s_flushed ##1 (!ed_v)[*2])
        else $error("stale fetch survived redirect");

    a_replay_refetch: assert property (
        replay && !i_redirect |=> o_bus_addr == $past(a2_addr) && !a1_v && !a2_v)
        else $error("dropped word not refetched");

endmodule : pfd_fetch

// file: testbench/pfd_mem_model.sv
`timescale 1ns/1ps
`include "pfd_map.svh"

// local-bus memory: address in, array cycle, return cycle, no wait states
module pfd_mem_model (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic [`PFD_BUS_W-1:0] i_addr,
    output logic [`PFD_BUS_W-1:0] o_rdata
);
    logic [`PFD_BUS_W-1:0] addr_q = '0;
    logic [`PFD_BUS_W-1:0] arr_q = '0;
    logic [`PFD_BUS_W-1:0] last = '0;
    logic take_q = 1'b0;
    logic ret_q = 1'b0;

    // opcode group and extension bit follow the word address
    function automatic logic [`PFD_BUS_W-1:0] image(input logic [`PFD_BUS_W-1:0] a);
        return {a[5:2], a[6], a[16:6], a[15:0]};
    endfunction : image

    // address registered here, array output registered one edge later
    always @(posedge i_clk) begin
        take_q <= i_req;
        addr_q <= i_addr;
        ret_q <= take_q;
        arr_q <= image(addr_q);
        last <= o_rdata;
    end

    // a word every clock; idle cycles show a changing pattern, not a stale word
    assign o_rdata = ret_q ? arr_q : ~last;
endmodule : pfd_mem_model

// file: testbench/pipelined_fetch_early_decode_tb.sv
`timescale 1ns/1ps
`include "pfd_map.svh"

module pipelined_fetch_early_decode_tb;
    import pfd_pkg::*;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_redirect = 1'b0;
    logic [31:0] i_redirect_addr = '0;
    logic o_bus_req;
    logic [31:0] o_bus_addr;
    logic [31:0] i_bus_rdata;
    logic o_inst_valid;
    pfd_item_t o_inst;
    logic i_inst_ready = 1'b1;
    int n_fail = 0;
    int checked = 0;
    logic [31:0] exp_addr = '0;

    pfd_fetch i_pfd_fetch (.i_clk(i_clk), .i_nrst(i_nrst), .i_redirect(i_redirect),
        .i_redirect_addr(i_redirect_addr), .o_bus_req(o_bus_req), .o_bus_addr(o_bus_addr),
        .i_bus_rdata(i_bus_rdata), .o_inst_valid(o_inst_valid), .o_inst(o_inst),
        .i_inst_ready(i_inst_ready));
    pfd_mem_model i_pfd_mem_model (.i_clk(i_clk), .i_req(o_bus_req), .i_addr(o_bus_addr),
        .o_rdata(i_bus_rdata));

    initial forever #2 i_clk = ~i_clk;

    // expected item: address, memory word and its table entry
    function automatic pfd_item_t exp_item(input logic [31:0] a);
        pfd_item_t t;
        t = '0;
        t.addr = a;
        t.instr = {a[5:2], a[6], a[16:6], a[15:0]};
        t.ctrl.len = 2'h1;
        t.ctrl.exec_cycles = 2'h1;
        case (t.instr[31:28])
            4'h2: begin t.ctrl.mem_read = 1'b1; t.ctrl.len = 2'h2; t.ctrl.exec_cycles = 2'h2; end
            4'h3: begin t.ctrl.mem_write = 1'b1; t.ctrl.len = 2'h2; end
            4'h6: begin t.ctrl.branch = 1'b1; t.ctrl.len = t.instr[27] ? 2'h3 : 2'h2; end
            default: ;
        endcase
        return t;
    endfunction : exp_item

    task automatic report_and_stop;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // inputs move 1 ns after the edge, outputs are settled there
    task automatic step;
        @(posedge i_clk);
        #1;
    endtask : step

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic chk_item(input pfd_item_t got, input pfd_item_t exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: item got %h exp %h", $time, got, exp);
        end
    endtask : chk_item

    // takes n items in program order; steady asks for one per clock
    task automatic take_items(input int n, input bit steady);
        int w;
        for (int i = 0; i < n; i++) begin
            w = 0;
            while (o_inst_valid !== 1'b1 && w < 20) begin
                step;
                w++;
            end
            if (o_inst_valid !== 1'b1) begin
                chk(0, 1, "no item");
                report_and_stop;
            end
            if (steady && i > 0) chk(w, 0, "gap in stream");
            chk(o_bus_req, 1, "bus idle");
            chk_item(o_inst, exp_item(exp_addr));
            exp_addr += 4;
            step;
        end
    endtask : take_items

    task automatic reset_and_stream;
        repeat (12) begin
            step;
            chk({o_bus_req, o_inst_valid}, 0, "busy in reset");
        end
        i_nrst = 1'b1;
        step;
        chk(o_bus_req, 1, "first request");
        chk(o_bus_addr, 32'h0000_0000, "first fetch");
        step;
        chk(o_bus_addr, 32'h0000_0004, "next fetch");
        take_items(40, 1);
    endtask : reset_and_stream

    // redirect to t: target on bus next cycle, first item five cycles later
    task automatic redirect(input logic [31:0] t);
        i_redirect = 1'b1;
        i_redirect_addr = t;
        step;
        i_redirect = 1'b0;
        chk(o_bus_addr, t & `PFD_WORD_MASK, "target");
        chk(o_inst_valid, 0, "stale item");
        repeat (3) begin
            step;
            chk(o_inst_valid, 0, "item in flight");
        end
        step;
        chk(o_inst_valid, 1, "late target");
        exp_addr = t & `PFD_WORD_MASK;
        take_items(20, 1);
    endtask : redirect

    // receiver stalls: the item stands, nothing is lost or repeated
    task automatic stall;
        i_inst_ready = 1'b0;
        repeat (12) begin
            step;
            chk(o_inst_valid, 1, "item dropped in stall");
            chk_item(o_inst, exp_item(exp_addr));
        end
        i_inst_ready = 1'b1;
        take_items(30, 0);
    endtask : stall

    task automatic back_to_back;
        i_redirect = 1'b1;
        i_redirect_addr = 32'h0000_8000;
        step;
        redirect(32'h0001_0023);
    endtask : back_to_back

    initial begin
        reset_and_stream;
        redirect(32'h0000_0403);
        stall;
        back_to_back;
        report_and_stop;
    end
endmodule : pipelined_fetch_early_decode_tb
